// *** hdl/wiu_pkg.sv ***
// Types shared by the wake-up interrupt unit
package wiu_pkg;

    // Stop sequence tracker, one-hot
    typedef enum logic [5:0] {
        SEQ_IDLE  = 6'b000001,
        SEQ_ONE   = 6'b000010,
        SEQ_ZERO  = 6'b000100,
        SEQ_ENTRY = 6'b001000,
        SEQ_STOP  = 6'b010000,
        SEQ_WAKE  = 6'b100000
    } wiu_seq_t;

    // Control register image
    typedef struct packed {
        logic stop;
        logic channel_source_select;
        logic wake_mode_select;
    } wiu_ctrl_t;

    // Outputs towards clock unit and interrupt channel
    typedef struct packed {
        logic stop_request;
        logic wake_event;
        logic shared_ext_channel;
        logic cpu_clk_en;
    } wiu_sys_t;

endpackage

// *** hdl/wiu_regs.svh ***
// Register indices, field positions, reset values and timing counts of the wake-up unit
`ifndef WIU_REGS_SVH
`define WIU_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define WIU_IDX_CTRL      8'hf9
`define WIU_IDX_MASK_HI   8'hfa
`define WIU_IDX_MASK_LO   8'hfb
`define WIU_IDX_EDGE_HI   8'hfc
`define WIU_IDX_EDGE_LO   8'hfd
`define WIU_IDX_PEND_HI   8'hfe
`define WIU_IDX_PEND_LO   8'hff

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define WIU_CTRL_WAKE     0
`define WIU_CTRL_SRC      1
`define WIU_CTRL_STOP     2
`define WIU_RST_BYTE      8'h00
`define WIU_RST_LINES     16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WIU_CLK_NS        20
`define WIU_ENTRY_CYC     2'd3
`define WIU_OSC_NS        20000
`define WIU_OSC_CYC       ((`WIU_OSC_NS + `WIU_CLK_NS - 1) / `WIU_CLK_NS)

`endif

// *** hdl/wiu_wakeup_unit.sv ***
// Sixteen-line wake-up and external interrupt unit with APB register access
//
// Contract
// - Writes of stop bit 1,0,1 in three consecutive writes raise the stop request.
// - Third write succeeds only in wake mode, no unmasked pending, some mask set.
// - In STOP, a wake-up event from an unmasked line clears the stop bit.
// - Stop bit reads one after the first write, and after a successful third.
// - Stop request is ORed with the active-low external stop pin.
// - Any other register write during the sequence aborts it.
// - Source select zero takes the dedicated pin; one takes the sixteen lines.
// - Wake mode bit zero gives interrupts only, one adds STOP wake-up sources.
// - Masked-in pending lines give channel request if select, wake event if mode.
// - A line with mask zero never yields wake event or line interrupt.
// - Polarity zero sets pending on falling edge, one on rising; high/low halves.
// - An edge during a polarity register write does not set pending.
// - Hardware sets pending on edge; only software clears; software may set.
// - Control, mask, polarity and pending registers reset to zero.
// - Clearing one pending while another remains must give a new rising edge.
// - After wake-up from STOP the clock resumes after the oscillator delay.
`timescale 1ns/100ps
`include "wiu_regs.svh"

module wiu_wakeup_unit (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // External lines
    input  wire logic [15:0]       wake_lines,
    input  wire logic              dedicated_ext_irq_pin,
    input  wire logic              ext_stop_n,
    // Writes elsewhere in the register file (interrupt, DMA, CPU)
    input  wire logic              ext_reg_write,
    // Towards clock unit and interrupt controller
    output wiu_pkg::wiu_sys_t      sys_out
);
    import wiu_pkg::*;
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0]  idx;
    logic        in_range;
    logic        mapped;
    logic        setup;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_other;
    logic        wr_edge_any;
    logic        wr_pend_any;
    // Index sits in word-address bits; upper and byte bits must be zero
    assign idx      = paddr[9:2];
    assign in_range = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign mapped   = in_range && (idx >= `WIU_IDX_CTRL);
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite;
    assign pready   = 1'b1; // Zero wait states
    // Write classification for the sequence tracker, polarity-write edge blocking and channel re-arm
    assign wr_ctrl     = wr && in_range && (idx == `WIU_IDX_CTRL);
    assign wr_other    = (wr && !wr_ctrl) || ext_reg_write;
    assign wr_edge_any = wr && in_range &&
                         ((idx == `WIU_IDX_EDGE_HI) || (idx == `WIU_IDX_EDGE_LO));
    assign wr_pend_any = wr && in_range &&
                         ((idx == `WIU_IDX_PEND_HI) || (idx == `WIU_IDX_PEND_LO));

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic        src_reg;
    logic        wake_reg;
    logic [15:0] mask_reg;
    logic [15:0] edge_reg;
    // Control bits written by software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else if (wr_ctrl) begin
            src_reg  <= pwdata[`WIU_CTRL_SRC];
            wake_reg <= pwdata[`WIU_CTRL_WAKE];
        end
    end

    // Mask halves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `WIU_RST_LINES;
        end else if (wr && in_range && idx == `WIU_IDX_MASK_HI) begin
            mask_reg[15:8] <= pwdata[7:0];
        end else if (wr && in_range && idx == `WIU_IDX_MASK_LO) begin
            mask_reg[7:0] <= pwdata[7:0];
        end
    end

    // Edge polarity halves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_reg <= `WIU_RST_LINES;
        end else if (wr && in_range && idx == `WIU_IDX_EDGE_HI) begin
            edge_reg[15:8] <= pwdata[7:0];
        end else if (wr && in_range && idx == `WIU_IDX_EDGE_LO) begin
            edge_reg[7:0] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Line sampling and pending flags
    // ------------------------------------------------------------------
    logic [15:0] prev_reg;
    logic        prev_valid_reg;
    logic [15:0] hw_set;
    logic [15:0] pend_reg;
    logic [15:0] pend_next;
    logic [15:0] pend_we;
    logic [15:0] pend_wval;
    // Previous line levels; first sample after reset only arms detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg       <= `WIU_RST_LINES;
            prev_valid_reg <= 1'b0;
        end else begin
            prev_reg       <= wake_lines;
            prev_valid_reg <= 1'b1;
        end
    end

    assign pend_we   = {{8{wr && in_range && idx == `WIU_IDX_PEND_HI}},
                        {8{wr && in_range && idx == `WIU_IDX_PEND_LO}}};
    assign pend_wval = {pwdata[7:0], pwdata[7:0]};

    // Per-line edge select and flag update; a hardware set beats a clear
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_line
            logic hit;
            assign hit = edge_reg[gi] ? (wake_lines[gi] && !prev_reg[gi])
                                      : (!wake_lines[gi] && prev_reg[gi]);
            assign hw_set[gi] = hit && prev_valid_reg && !wr_edge_any;
            assign pend_next[gi] = (pend_we[gi] ? pend_wval[gi] : pend_reg[gi])
                                   | hw_set[gi];
        end
    endgenerate

    // Pending flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= `WIU_RST_LINES;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // ------------------------------------------------------------------
    // Line request, wake event and shared channel
    // ------------------------------------------------------------------
    logic        line_any;
    logic        wake_evt;
    logic        shared_reg;
    assign line_any = |(mask_reg & pend_reg);
    assign wake_evt = wake_reg && line_any;

    // Channel request is registered; a pending write drops it for one
    // cycle so any flag still set makes a fresh rising edge afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_reg <= 1'b0;
        end else if (src_reg) begin
            shared_reg <= line_any && !wr_pend_any;
        end else begin
            shared_reg <= dedicated_ext_irq_pin;
        end
    end

    // ------------------------------------------------------------------
    // Stop sequence tracker
    // ------------------------------------------------------------------
    wiu_seq_t    seq_reg;
    wiu_seq_t    seq_next;
    logic [1:0]  entry_cnt_reg;
    logic [15:0] osc_cnt_reg;
    logic        stop_ok;
    logic        stop_wbit;
    logic        stop_bit;
    assign stop_wbit = pwdata[`WIU_CTRL_STOP];
    assign stop_ok   = wake_reg && !line_any && (|mask_reg);

    // Next state
    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            SEQ_IDLE: begin
                if (wr_ctrl && !ext_reg_write && stop_wbit) begin
                    seq_next = SEQ_ONE;
                end
            end
            SEQ_ONE: begin
                if (wr_other) begin
                    seq_next = SEQ_IDLE;
                end else if (wr_ctrl) begin
                    seq_next = stop_wbit ? SEQ_ONE : SEQ_ZERO;
                end
            end
            SEQ_ZERO: begin
                if (wr_other) begin
                    seq_next = SEQ_IDLE;
                end else if (wr_ctrl) begin
                    if (stop_wbit && stop_ok) begin
                        seq_next = SEQ_ENTRY;
                    end else begin
                        seq_next = SEQ_IDLE;
                    end
                end
            end
            SEQ_ENTRY: begin
                // Entry takes a few cycles; a write or wake-up here cancels
                if (wr || ext_reg_write || wake_evt) begin
                    seq_next = SEQ_IDLE;
                end else if (entry_cnt_reg == `WIU_ENTRY_CYC - 2'd1) begin
                    seq_next = SEQ_STOP;
                end
            end
            SEQ_STOP: begin
                if (wake_evt) begin
                    seq_next = SEQ_WAKE;
                end
            end
            SEQ_WAKE: begin
                if (osc_cnt_reg == 16'(`WIU_OSC_CYC - 1)) begin
                    seq_next = SEQ_IDLE;
                end
            end
            default: begin
                seq_next = SEQ_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // Entry and oscillator restart counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_cnt_reg <= 2'd0;
            osc_cnt_reg   <= 16'd0;
        end else begin
            entry_cnt_reg <= (seq_reg == SEQ_ENTRY) ? entry_cnt_reg + 2'd1 : 2'd0;
            osc_cnt_reg   <= (seq_reg == SEQ_WAKE) ? osc_cnt_reg + 16'd1 : 16'd0;
        end
    end

    // Stop bit is one after the first write and once the sequence succeeded
    assign stop_bit = (seq_reg == SEQ_ONE) || (seq_reg == SEQ_ENTRY) ||
                      (seq_reg == SEQ_STOP);

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sys_out.stop_request = (seq_reg == SEQ_ENTRY) || (seq_reg == SEQ_STOP) ||
                                  !ext_stop_n;
    assign sys_out.wake_event         = wake_evt;
    assign sys_out.shared_ext_channel = shared_reg;
    assign sys_out.cpu_clk_en = !((seq_reg == SEQ_STOP) || (seq_reg == SEQ_WAKE));

    // ------------------------------------------------------------------
    // Read data and error, captured in the setup cycle
    // ------------------------------------------------------------------
    wiu_ctrl_t   ctrl_rd;
    logic [7:0]  rd_byte;
    assign ctrl_rd = '{stop: stop_bit, channel_source_select: src_reg,
                       wake_mode_select: wake_reg};

    // Read mux, reserved bits as zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            `WIU_IDX_CTRL:    rd_byte = {5'h00, ctrl_rd};
            `WIU_IDX_MASK_HI: rd_byte = mask_reg[15:8];
            `WIU_IDX_MASK_LO: rd_byte = mask_reg[7:0];
            `WIU_IDX_EDGE_HI: rd_byte = edge_reg[15:8];
            `WIU_IDX_EDGE_LO: rd_byte = edge_reg[7:0];
            `WIU_IDX_PEND_HI: rd_byte = pend_reg[15:8];
            `WIU_IDX_PEND_LO: rd_byte = pend_reg[7:0];
            default:          rd_byte = 8'h00;
        endcase
    end

    // Data held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_stop_pin_force: assert property (!ext_stop_n |-> sys_out.stop_request)
        else $error("stop pin low without stop request");
    chk_first_write_bit: assert property (
        (seq_reg == SEQ_IDLE && wr_ctrl && !ext_reg_write && stop_wbit)
        |=> stop_bit && !sys_out.stop_request || !ext_stop_n)
        else $error("stop bit not one after first write");
    chk_seq_success: assert property (
        (seq_reg == SEQ_ZERO && wr_ctrl && !ext_reg_write && stop_wbit && stop_ok)
        |=> sys_out.stop_request && stop_bit)
        else $error("good sequence gave no stop request");
    chk_seq_refused: assert property (
        (seq_reg == SEQ_ZERO && wr_ctrl && stop_wbit && !stop_ok) |=> !stop_bit)
        else $error("refused sequence left stop bit set");
    chk_abort_write: assert property (
        ((seq_reg == SEQ_ONE || seq_reg == SEQ_ZERO) && wr_other)
        |=> seq_reg == SEQ_IDLE ##1 !stop_bit || seq_reg == SEQ_ONE)
        else $error("foreign write did not abort sequence");
    chk_wake_clears: assert property (
        (seq_reg == SEQ_STOP && wake_evt) |=> !stop_bit && !sys_out.cpu_clk_en)
        else $error("wake-up did not clear stop bit");
    chk_osc_delay: assert property (
        $rose(seq_reg == SEQ_WAKE) |-> !sys_out.cpu_clk_en [*8])
        else $error("clock resumed before oscillator delay");
    chk_mask_gates: assert property (
        sys_out.wake_event |-> (|(mask_reg & pend_reg)) && wake_reg)
        else $error("wake event without unmasked pending line");
    chk_pin_source: assert property (
        (!src_reg && !$past(src_reg)) |-> shared_reg == $past(dedicated_ext_irq_pin))
        else $error("channel not following dedicated pin");
    chk_edge_sets: assert property (
        (|hw_set) |=> ((pend_reg & $past(hw_set)) == $past(hw_set)))
        else $error("detected edge did not set pending");
    chk_edge_blocked: assert property (
        wr_edge_any |=> ((pend_reg & ~$past(pend_reg)) == 16'h0000 || $past(pend_we) != 0))
        else $error("edge set pending during polarity write");
    chk_rearm_edge: assert property (
        (src_reg && wr_pend_any) |=> !shared_reg)
        else $error("pending write did not drop channel request");
    cov_stop_entered: cover property ($rose(seq_reg == SEQ_STOP));
    cov_wake_exit:    cover property (seq_reg == SEQ_WAKE ##1 seq_reg == SEQ_IDLE);
    cov_seq_abort:    cover property (seq_reg == SEQ_ZERO ##1 seq_reg == SEQ_IDLE);
    cov_line_irq:     cover property (src_reg && $rose(shared_reg));

endmodule

// *** tb/wiu_line_partner.sv ***
// Model of the wake-up lines, the dedicated pin and the shared interrupt channel
`timescale 1ns/100ps
module wiu_line_partner (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Channel request from the unit
    input  wire logic        shared_ext_channel,
    // Lines towards the unit
    output logic      [15:0] wake_lines,
    output logic             irq_pin
);
    logic chan_q;
    int   chan_edges;

    // Quiet lines from time zero
    initial begin
        wake_lines = 16'h0000;
        irq_pin    = 1'b0;
    end

    // Levels move only just after an edge and then hold, so no glitch reaches the unit
    task automatic drive(input logic [15:0] lines, input logic pin);
        @(posedge pclk);
        wake_lines <= lines;
        irq_pin    <= pin;
    endtask

    // The channel reacts to a rising request only, so a level held high is one event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_q     <= 1'b0;
            chan_edges <= 0;
        end else begin
            chan_q <= shared_ext_channel;
            if (shared_ext_channel && !chan_q) begin
                chan_edges <= chan_edges + 1;
            end
        end
    end
endmodule

// *** tb/wiu_wakeup_unit_tb_top.sv ***
// Self-checking bench of the wake-up interrupt unit
`timescale 1ns/100ps
`include "wiu_regs.svh"
module wiu_wakeup_unit_tb_top;
    import wiu_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ext_stop_n, ext_reg_write, irq_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] lines;
    wiu_sys_t    sys;
    int          err_count, n_compared;

    wiu_wakeup_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_lines(lines), .dedicated_ext_irq_pin(irq_pin),
        .ext_stop_n(ext_stop_n), .ext_reg_write(ext_reg_write), .sys_out(sys));
    wiu_line_partner peer (.pclk(pclk), .presetn(presetn),
        .shared_ext_channel(sys.shared_ext_channel), .wake_lines(lines), .irq_pin(irq_pin));

    // Clock, 20 ns period
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high, released at that edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, idx, d, q, e);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, idx, 8'h00, q, e);
        check(what, q, {24'h000000, exp});
    endtask

    // Bounded wait on one output bit: 3 stop, 2 wake, 1 channel, 0 clock enable
    task automatic wait_sys(input string what, input int b, input logic v, input int lim);
        int n;
        #1;
        for (n = 0; n < lim && sys[b] !== v; n++) begin
            @(posedge pclk);
            #1;
        end
        check(what, sys[b], v);
    endtask

    // A register write elsewhere in the register file
    task automatic pulse_other();
        @(posedge pclk);
        ext_reg_write <= 1'b1;
        @(posedge pclk);
        ext_reg_write <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        logic [7:0]  i;
        for (i = `WIU_IDX_CTRL; i != 8'h00; i++) rdchk("reset", i, 8'h00);
        #1;
        check("outputs", {28'h0, sys}, 32'h1);
        apb(1'b0, 8'hf0, 8'h00, q, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", q, 32'h0);
        for (i = `WIU_IDX_MASK_HI; i != `WIU_IDX_PEND_HI; i++) begin
            wr(i, 8'ha5 ^ i);
            rdchk("rw", i, 8'ha5 ^ i);
            wr(i, 8'h00);
        end
        wr(`WIU_IDX_CTRL, 8'h03);
        rdchk("ctrl rw", `WIU_IDX_CTRL, 8'h03);
        wr(`WIU_IDX_CTRL, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_edges();
        wr(`WIU_IDX_EDGE_HI, 8'h80);
        wr(`WIU_IDX_EDGE_LO, 8'h0f);
        peer.drive(16'hffff, 1'b0);
        rdchk("rise hi", `WIU_IDX_PEND_HI, 8'h80);
        rdchk("rise lo", `WIU_IDX_PEND_LO, 8'h0f);
        peer.drive(16'h0000, 1'b0);
        rdchk("fall hi", `WIU_IDX_PEND_HI, 8'hff);
        rdchk("fall lo", `WIU_IDX_PEND_LO, 8'hff);
        wr(`WIU_IDX_PEND_HI, 8'h00);
        wr(`WIU_IDX_PEND_LO, 8'h40);
        rdchk("sw clear", `WIU_IDX_PEND_HI, 8'h00);
        rdchk("sw set", `WIU_IDX_PEND_LO, 8'h40);
        wr(`WIU_IDX_PEND_LO, 8'h00);
        // Rising edge on line 0 lands in the access cycle of a polarity write
        fork
            wr(`WIU_IDX_EDGE_LO, 8'h0f);
            begin
                @(posedge pclk);
                peer.drive(16'h0001, 1'b0);
            end
        join
        rdchk("edge in write", `WIU_IDX_PEND_LO, 8'h00);
        $display("edge test done");
    endtask

    task automatic t_channel();
        int n;
        peer.drive(16'h0000, 1'b1);
        wait_sys("pin to channel", 1, 1'b1, 4);
        wr(`WIU_IDX_PEND_LO, 8'h03);
        wr(`WIU_IDX_MASK_LO, 8'h03);
        peer.drive(16'h0000, 1'b0);
        repeat (4) @(posedge pclk);
        wait_sys("lines blocked", 1, 1'b0, 1);
        wait_sys("no wake", 2, 1'b0, 1);
        wr(`WIU_IDX_CTRL, 8'h02);
        wait_sys("lines to channel", 1, 1'b1, 4);
        wait_sys("still no wake", 2, 1'b0, 1);
        wr(`WIU_IDX_CTRL, 8'h03);
        wait_sys("wake on", 2, 1'b1, 3);
        n = peer.chan_edges;
        wr(`WIU_IDX_PEND_LO, 8'h02);
        repeat (4) @(posedge pclk);
        check("fresh edge", peer.chan_edges, n + 1);
        wr(`WIU_IDX_MASK_LO, 8'h00);
        wait_sys("masked wake", 2, 1'b0, 3);
        wait_sys("masked channel", 1, 1'b0, 3);
        wr(`WIU_IDX_PEND_LO, 8'h00);
        wr(`WIU_IDX_CTRL, 8'h00);
        $display("channel test done");
    endtask

    task automatic t_stop_fail();
        int c;
        for (c = 0; c < 5; c++) begin
            wr(`WIU_IDX_MASK_LO, (c == 2) ? 8'h00 : 8'h01);
            wr(`WIU_IDX_PEND_LO, (c == 1) ? 8'h01 : 8'h00);
            wr(`WIU_IDX_CTRL, (c == 0) ? 8'h04 : 8'h05);
            if (c == 3) wr(`WIU_IDX_EDGE_LO, 8'h0f);
            if (c == 4) pulse_other();
            wr(`WIU_IDX_CTRL, (c == 0) ? 8'h00 : 8'h01);
            wr(`WIU_IDX_CTRL, (c == 0) ? 8'h04 : 8'h05);
            repeat (6) @(posedge pclk);
            wait_sys("no stop", 3, 1'b0, 1);
            wait_sys("clock kept", 0, 1'b1, 1);
            rdchk("stop bit", `WIU_IDX_CTRL, (c > 2) ? 8'h05 : {7'h0, c != 0});
        end
        $display("refused stop test done");
    endtask

    task automatic t_stop_ok();
        wr(`WIU_IDX_MASK_LO, 8'h01);
        wr(`WIU_IDX_PEND_LO, 8'h00);
        wr(`WIU_IDX_CTRL, 8'h05);
        rdchk("after first", `WIU_IDX_CTRL, 8'h05);
        wr(`WIU_IDX_CTRL, 8'h01);
        rdchk("after second", `WIU_IDX_CTRL, 8'h01);
        wr(`WIU_IDX_CTRL, 8'h05);
        pulse_other();
        repeat (6) @(posedge pclk);
        wait_sys("entry cancelled", 0, 1'b1, 1);
        wait_sys("request dropped", 3, 1'b0, 1);
        wr(`WIU_IDX_CTRL, 8'h05);
        wr(`WIU_IDX_CTRL, 8'h01);
        wr(`WIU_IDX_CTRL, 8'h05);
        wait_sys("stop request", 3, 1'b1, 2);
        wait_sys("clock stopped", 0, 1'b0, 8);
        rdchk("stop bit set", `WIU_IDX_CTRL, 8'h05);
        peer.drive(16'h0001, 1'b0);
        wait_sys("wake event", 2, 1'b1, 5);
        wait_sys("request off", 3, 1'b0, 2);
        rdchk("stop cleared", `WIU_IDX_CTRL, 8'h01);
        repeat (900) @(posedge pclk);
        wait_sys("oscillator wait", 0, 1'b0, 1);
        wait_sys("clock back", 0, 1'b1, 200);
        peer.drive(16'h0000, 1'b0);
        wr(`WIU_IDX_PEND_LO, 8'h00);
        wr(`WIU_IDX_CTRL, 8'h00);
        $display("stop test done");
    endtask

    task automatic t_pin();
        @(posedge pclk);
        ext_stop_n <= 1'b0;
        wait_sys("pin stop", 3, 1'b1, 2);
        rdchk("bit untouched", `WIU_IDX_CTRL, 8'h00);
        @(posedge pclk);
        ext_stop_n <= 1'b1;
        wait_sys("pin release", 3, 1'b0, 2);
        $display("stop pin test done");
    endtask

    // Reset for five cycles, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_stop_n = 1'b1;
        ext_reg_write = 1'b0;
        err_count = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_edges();
        t_channel();
        t_stop_fail();
        t_stop_ok();
        t_pin();
        complete_run();
    end
endmodule
